// ===== hdl/cctr_top.sv
`default_nettype none
module cctr_top
    import cctr_pkg::*;
(
    input wire logic mclk, // System clock, 25 MHz
    input wire logic reset_n, // Power-on reset, active low
    input wire cctr_req_t req, // Host register request
    output cctr_rsp_t rsp_r, // Answer with read data
    input wire cctr_sense_t sense, // Integrator results
    input wire logic tick_fast, // Timebase pulse, 0.8789 s
    input wire logic [2:0] temp_band, // 0 below 0 C .. 7 above 60 C
    input wire logic [2:0] sense_mag, // Sense magnitude, threshold units
    input wire logic pd_cmd, // Power-down command pulse
    input wire logic link_wake, // Link transition pulse
    input wire logic supply_low, // Supply below power-on level
    input wire logic gpio_in, // General-purpose pin level
    output logic gpio_out, // Pin drive value
    output logic gpio_oe_n, // Pin driven when low
    output logic gpio_level_r, // Synchronised pin level
    output logic sleep_r, // Device asleep
    output logic brief_wake_r // Short maintenance wake
);

    cctr_st_t st_r; // Registered state except the counters
    cctr_st_t st_nxt; // Its next value

    logic [15:0] dc_cnt; // Discharge count
    logic [15:0] cc_cnt; // Charge count
    logic [15:0] sd_cnt; // Self-discharge count
    logic [15:0] dt_cnt; // Discharge time
    logic [15:0] ct_cnt; // Charge time
    logic dt_wrap; // Discharge time rollover
    logic ct_wrap; // Charge time rollover
    logic awake; // Not in deep sleep
    logic base_tick; // Timebase tick, awake or parked in sleep
    logic sd_step; // Timebase step for self-discharge
    logic sd_inc; // Self-discharge increment
    logic slow_hit; // Slow-rate prescaler terminal
    logic dt_inc; // Discharge time increment
    logic ct_inc; // Charge time increment
    logic wr_en; // Host write accepted

    // Byte select of a counter pair
    function automatic logic [7:0] cnt_byte(input logic [15:0] cnt, input logic hi);
        cnt_byte = hi ? cnt[15:8] : cnt[7:0];
    endfunction : cnt_byte

    // Prescaler terminal for the temperature band
    function automatic logic [6:0] sd_last(input logic [2:0] band);
        logic [2:0] sh;
        sh = SD_BAND_TOP - band;
        sd_last = 7'((8'h01 << sh) - 8'h01);
    endfunction : sd_last

    // Read-back mux; unmapped addresses read zero
    function automatic logic [7:0] rd_mux(input logic [6:0] addr, input cctr_st_t s,
                                          input logic [15:0] dc, input logic [15:0] cc,
                                          input logic [15:0] sd, input logic [15:0] dt,
                                          input logic [15:0] ct);
        case (addr)
            ADDR_CLEAR: rd_mux = {3'h0, s.clr};
            ADDR_MODE: rd_mux = s.mode;
            ADDR_CT_LO: rd_mux = cnt_byte(ct, 1'b0);
            ADDR_CT_HI: rd_mux = cnt_byte(ct, 1'b1);
            ADDR_DT_LO: rd_mux = cnt_byte(dt, 1'b0);
            ADDR_DT_HI: rd_mux = cnt_byte(dt, 1'b1);
            ADDR_SD_LO: rd_mux = cnt_byte(sd, 1'b0);
            ADDR_SD_HI: rd_mux = cnt_byte(sd, 1'b1);
            ADDR_CC_LO: rd_mux = cnt_byte(cc, 1'b0);
            ADDR_CC_HI: rd_mux = cnt_byte(cc, 1'b1);
            ADDR_DC_LO: rd_mux = cnt_byte(dc, 1'b0);
            ADDR_DC_HI: rd_mux = cnt_byte(dc, 1'b1);
            default: rd_mux = 8'h00;
        endcase
    endfunction : rd_mux

    // Discharge count
    cctr_counter16 u_dc (
        .mclk(mclk),
        .reset_n(reset_n),
        .clr(st_r.clr[CLR_DCHG_BIT]),
        .inc(sense.dchg_pulse),
        .cnt_r(dc_cnt),
        .wrap()
    );

    // Charge count
    cctr_counter16 u_cc (
        .mclk(mclk),
        .reset_n(reset_n),
        .clr(st_r.clr[CLR_CHG_BIT]),
        .inc(sense.chg_pulse),
        .cnt_r(cc_cnt),
        .wrap()
    );

    // Self-discharge count
    cctr_counter16 u_sd (
        .mclk(mclk),
        .reset_n(reset_n),
        .clr(st_r.clr[CLR_SELF_BIT]),
        .inc(sd_inc),
        .cnt_r(sd_cnt),
        .wrap()
    );

    // Discharge time
    cctr_counter16 u_dt (
        .mclk(mclk),
        .reset_n(reset_n),
        .clr(st_r.clr[CLR_DTIME_BIT]),
        .inc(dt_inc),
        .cnt_r(dt_cnt),
        .wrap(dt_wrap)
    );

    // Charge time
    cctr_counter16 u_ct (
        .mclk(mclk),
        .reset_n(reset_n),
        .clr(st_r.clr[CLR_CTIME_BIT]),
        .inc(ct_inc),
        .cnt_r(ct_cnt),
        .wrap(ct_wrap)
    );

    // Increment terms shared by the counters and the state update
    always_comb begin
        awake = (st_r.pwr == PWR_RUN) || (st_r.pwr == PWR_ARMED);
        // Asleep, the tick is parked and consumed during the brief wake
        if (st_r.pwr == PWR_BRIEF) begin
            base_tick = st_r.tick_pend;
        end else begin
            base_tick = awake && tick_fast;
        end
        slow_hit = st_r.psc == SLOW_LAST;
        // Hottest band steps at 16 per hour, the slow prescaler terminal
        sd_step = base_tick && slow_hit;
        sd_inc = sd_step && (st_r.sd_psc >= sd_last(temp_band));
        // Fast rate each tick; slow rate once per prescaler turn
        dt_inc = awake && tick_fast && sense.dchg_active
                 && (!st_r.mode[MODE_SDT_BIT] || slow_hit);
        ct_inc = awake && tick_fast && sense.chg_active
                 && (!st_r.mode[MODE_SCT_BIT] || slow_hit);
        wr_en = req.valid && req.cmd.write;
    end

    // Next-state logic
    always_comb begin
        st_nxt = st_r;

        // Pin and supply synchronisers
        st_nxt.gpio_sync = {st_r.gpio_sync[0], gpio_in};
        st_nxt.low_sync = {st_r.low_sync[0], supply_low};
        st_nxt.gpio_lvl = st_r.gpio_sync[1];

        // Shared slow prescaler runs on every tick, parked sleep ticks too
        if (base_tick) begin
            st_nxt.psc = st_r.psc + 8'h01;
        end

        // Self-discharge prescaler, restarted at its terminal
        if (sd_step) begin
            st_nxt.sd_psc = sd_inc ? 7'h00 : st_r.sd_psc + 7'h01;
        end

        // Clear bits done this cycle drop back to zero
        st_nxt.clr = CLEAR_RESET;

        // Rollover toggles the slow flag: set first, cleared second
        if (dt_wrap) begin
            st_nxt.mode[MODE_SDT_BIT] = !st_r.mode[MODE_SDT_BIT];
        end
        if (ct_wrap) begin
            st_nxt.mode[MODE_SCT_BIT] = !st_r.mode[MODE_SCT_BIT];
        end

        // Host writes
        if (wr_en) begin
            case (req.cmd.addr)
                ADDR_CLEAR: begin
                    // Upper bits are ignored; the host keeps them zero
                    st_nxt.clr = req.wdata[4:0];
                end
                ADDR_MODE: begin
                    // Slow flags are hardware-owned
                    st_nxt.mode = (st_r.mode & ~MODE_WR_MASK)
                                  | (req.wdata & MODE_WR_MASK);
                    if (dt_wrap) begin
                        st_nxt.mode[MODE_SDT_BIT] = !st_r.mode[MODE_SDT_BIT];
                    end
                    if (ct_wrap) begin
                        st_nxt.mode[MODE_SCT_BIT] = !st_r.mode[MODE_SCT_BIT];
                    end
                end
                default: begin
                    // Read-only or unmapped: no effect
                end
            endcase
        end

        // Clearing a time counter also returns it to the fast rate
        if (st_r.clr[CLR_DTIME_BIT]) begin
            st_nxt.mode[MODE_SDT_BIT] = 1'b0;
        end
        if (st_r.clr[CLR_CTIME_BIT]) begin
            st_nxt.mode[MODE_SCT_BIT] = 1'b0;
        end

        // Supply dip sets the flag; set wins over a host write
        if (st_r.low_sync[1]) begin
            st_nxt.mode[MODE_POR_BIT] = 1'b1;
        end

        // Open-drain pin: drive low only when output and level is 0
        st_nxt.gpio_out = 1'b0;
        st_nxt.gpio_oe_n = st_nxt.mode[MODE_DIR_BIT]
                           || st_nxt.mode[MODE_LVL_BIT];

        // Power state
        st_nxt.brief = 1'b0;
        case (st_r.pwr)
            PWR_RUN: begin
                if (pd_cmd) begin
                    st_nxt.pwr = PWR_ARMED;
                end
            end
            PWR_ARMED: begin
                // Zero threshold means sleep at once
                if (st_r.mode[3:MODE_THR_LSB] == 3'h0
                    || sense_mag < st_r.mode[3:MODE_THR_LSB]) begin
                    st_nxt.pwr = PWR_SLEEP;
                end
            end
            PWR_SLEEP: begin
                if (link_wake) begin
                    st_nxt.pwr = PWR_RUN;
                end else if (tick_fast) begin
                    st_nxt.pwr = PWR_BRIEF;
                    st_nxt.tick_pend = 1'b1;
                    st_nxt.brief = 1'b1;
                end
            end
            PWR_BRIEF: begin
                st_nxt.tick_pend = 1'b0;
                st_nxt.pwr = link_wake ? PWR_RUN : PWR_SLEEP;
            end
            default: begin
                st_nxt.pwr = PWR_RUN;
            end
        endcase

        // One answer per request, one cycle later
        st_nxt.rsp.valid = req.valid;
        if (req.valid && !req.cmd.write) begin
            st_nxt.rsp.rdata = rd_mux(req.cmd.addr, st_r, dc_cnt, cc_cnt,
                                      sd_cnt, dt_cnt, ct_cnt);
        end else begin
            st_nxt.rsp.rdata = 8'h00;
        end
    end

    // State register; constants only under reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flops, except sleep_r, decoded from the power state
    assign rsp_r = st_r.rsp;
    assign gpio_out = st_r.gpio_out;
    assign gpio_oe_n = st_r.gpio_oe_n;
    assign gpio_level_r = st_r.gpio_lvl;
    assign sleep_r = (st_r.pwr == PWR_SLEEP);
    assign brief_wake_r = st_r.brief;

endmodule : cctr_top
`default_nettype wire

// ===== hdl/cctr_pkg.sv
// Behaviour
// - Discharge counter counts discharge, wraps past FFFFH
// - Charge counter counts charge, wraps past FFFFH
// - Self-discharge counter runs awake and asleep
// - Self-discharge rate doubles per band, 1/8h..16/h
// - Sleep wakes briefly to advance self-discharge
// - Discharge time counts 4096 per hour
// - Discharge time wrap sets slow flag, 16/hour
// - Second discharge time wrap clears slow flag
// - Charge time counts 4096 per hour
// - Charge time wrap sets slow flag, 16/hour
// - Second charge time wrap clears slow flag
// - Mode bit 7: pin input, reset 0
// - Mode bit 6: open-drain release, reset 1
// - Mode bits 3:1 sleep threshold, reset ones
// - Mode bit 0 power flag, host writable
// - Clear bits 0..2 zero counters, self-clear
// - Clear bits 4,3 zero time counters, flags
// - Time counter clear restores fast rate
`default_nettype none
package cctr_pkg;

    // Register addresses
    localparam logic [6:0] ADDR_CLEAR = 7'h63;
    localparam logic [6:0] ADDR_MODE = 7'h64;
    localparam logic [6:0] ADDR_CT_LO = 7'h65;
    localparam logic [6:0] ADDR_CT_HI = 7'h66;
    localparam logic [6:0] ADDR_DT_LO = 7'h67;
    localparam logic [6:0] ADDR_DT_HI = 7'h68;
    localparam logic [6:0] ADDR_SD_LO = 7'h69;
    localparam logic [6:0] ADDR_SD_HI = 7'h6A;
    localparam logic [6:0] ADDR_CC_LO = 7'h6B;
    localparam logic [6:0] ADDR_CC_HI = 7'h6C;
    localparam logic [6:0] ADDR_DC_LO = 7'h6D;
    localparam logic [6:0] ADDR_DC_HI = 7'h6E;

    // Clear register bit positions
    localparam int CLR_DCHG_BIT = 0;
    localparam int CLR_CHG_BIT = 1;
    localparam int CLR_SELF_BIT = 2;
    localparam int CLR_DTIME_BIT = 3;
    localparam int CLR_CTIME_BIT = 4;
    localparam logic [4:0] CLEAR_RESET = 5'h00;

    // Mode register bit positions
    localparam int MODE_DIR_BIT = 7;
    localparam int MODE_LVL_BIT = 6;
    localparam int MODE_SCT_BIT = 5;
    localparam int MODE_SDT_BIT = 4;
    localparam int MODE_THR_LSB = 1;
    localparam int MODE_POR_BIT = 0;
    localparam logic [7:0] MODE_RESET = 8'h4F;
    localparam logic [7:0] MODE_WR_MASK = 8'hCF;

    // Command byte write flag
    localparam int CMD_WRITE_BIT = 7;

    // Time counter rates per hour; the fast tick comes every 0.8789 s
    localparam int RATE_FAST_PER_HOUR = 4096;
    localparam int RATE_SLOW_PER_HOUR = 16;
    localparam logic [7:0] SLOW_LAST = 8'((RATE_FAST_PER_HOUR / RATE_SLOW_PER_HOUR) - 1);
    localparam logic [2:0] SD_BAND_TOP = 3'h7;

    // Carriers
    typedef struct packed {
        logic write;
        logic [6:0] addr;
    } cctr_cmd_t;

    typedef struct packed {
        logic valid;
        cctr_cmd_t cmd;
        logic [7:0] wdata;
    } cctr_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
    } cctr_rsp_t;

    typedef struct packed {
        logic chg_pulse;
        logic dchg_pulse;
        logic chg_active;
        logic dchg_active;
    } cctr_sense_t;

    typedef enum logic [1:0] {PWR_RUN, PWR_ARMED, PWR_SLEEP, PWR_BRIEF} cctr_pwr_t;

    typedef struct packed {
        logic [15:0] cnt;
    } cctr_cnt_t;

    typedef struct packed {
        logic [4:0] clr;
        logic [7:0] mode;
        logic [7:0] psc;
        logic [6:0] sd_psc;
        cctr_pwr_t pwr;
        logic tick_pend;
        logic [1:0] gpio_sync;
        logic [1:0] low_sync;
        logic gpio_lvl;
        logic gpio_oe_n;
        logic gpio_out;
        logic brief;
        cctr_rsp_t rsp;
    } cctr_st_t;

    localparam cctr_st_t ST_RESET = '{
        clr: CLEAR_RESET, mode: MODE_RESET, psc: 8'h00, sd_psc: 7'h00,
        pwr: PWR_RUN, tick_pend: 1'b0, gpio_sync: 2'h0, low_sync: 2'h0,
        gpio_lvl: 1'b0, gpio_oe_n: 1'b1, gpio_out: 1'b0, brief: 1'b0,
        rsp: '{valid: 1'b0, rdata: 8'h00}};

endpackage : cctr_pkg
`default_nettype wire

// ===== hdl/cctr_counter16.sv
`default_nettype none
module cctr_counter16
    import cctr_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic clr, // Zero the count
    input wire logic inc, // Advance by one
    output logic [15:0] cnt_r, // Current count
    output logic wrap // Pulse on FFFFH to zero
);

    cctr_cnt_t st_r; // Registered state
    cctr_cnt_t st_nxt; // Next state

    // Clear first, then increment with free wrap
    always_comb begin
        st_nxt = st_r;
        if (clr) begin
            st_nxt.cnt = 16'h0000;
        end else if (inc) begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
    end

    // Wrap is seen only on a real increment, never on a clear
    assign wrap = inc && !clr && (st_r.cnt == 16'hFFFF);

    // State register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '{cnt: 16'h0000};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cnt_r = st_r.cnt;

endmodule : cctr_counter16
`default_nettype wire

// ===== verification/cctr_host_model.sv
`default_nettype none
module cctr_host_model
    import cctr_pkg::*;
(
    output cctr_req_t req, // Request to the device
    input wire logic mclk, // System clock
    input wire cctr_rsp_t rsp // Answer from the device
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle until the first transfer
    initial begin
        req = '0;
    end

    // One access; the request stands one cycle, the answer is taken an edge later
    task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic got);
        logic [7:0] wd;
        wd = (addr == ADDR_CLEAR) ? (wdata & 8'h1F) : wdata;
        @(posedge mclk);
        req <= '{valid: 1'b1, cmd: '{write: wr, addr: addr}, wdata: wd};
        @(posedge mclk);
        req <= '0;
        @(posedge mclk);
        rdata = rsp.rdata;
        got = rsp.valid;
    endtask : xfer

endmodule : cctr_host_model
`default_nettype wire

// ===== verification/cctr_asserts.sv
`default_nettype none
module cctr_asserts
    import cctr_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic reset_n, // Reset, active low
    input wire cctr_req_t req, // Host request
    input wire cctr_rsp_t rsp_r, // Device answer
    input wire logic tick_fast, // Timebase pulse
    input wire logic supply_low, // Supply dip
    input wire logic gpio_in, // Pin level
    input wire logic gpio_out, // Pin drive
    input wire logic gpio_oe_n, // Pin enable
    input wire logic gpio_level_r, // Synced level
    input wire logic sleep_r, // Asleep
    input wire logic brief_wake_r // Maintenance wake
);
    timeunit 1ns;
    timeprecision 1ps;

    // Decoded host accesses
    wire logic rd_any = req.valid && !req.cmd.write; // Any read
    wire logic wr_mode = req.valid && req.cmd.write && req.cmd.addr == ADDR_MODE; // Mode write
    wire logic wr_clr = req.valid && req.cmd.write && req.cmd.addr == ADDR_CLEAR; // Clear write
    wire logic rd_out = rd_any && (req.cmd.addr < ADDR_CLEAR || req.cmd.addr > ADDR_DC_HI); // Unmapped

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    // Every request gets exactly one answer, one edge later
    property p_rsp;
        rsp_r.valid == $past(req.valid);
    endproperty
    a_rsp: assert property (p_rsp) else $error("answer not one cycle after request");
    property p_unmap;
        rd_out |=> rsp_r.rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    // Clear bits live for one cycle only
    property p_clr_self;
        rd_any && req.cmd.addr == ADDR_CLEAR && !$past(wr_clr) |=> rsp_r.rdata == 8'h00;
    endproperty
    a_clr_self: assert property (p_clr_self) else $error("clear bits did not self-clear");
    property p_od;
        gpio_out == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("pin driven high");
    property p_drive;
        wr_mode && req.wdata[7:6] == 2'b00 |-> ##[1:2] !gpio_oe_n;
    endproperty
    a_drive: assert property (p_drive) else $error("pin not driven low");
    property p_input;
        wr_mode && req.wdata[7] |-> ##[1:2] gpio_oe_n;
    endproperty
    a_input: assert property (p_input) else $error("input pin still driven");
    // Enable moves only after a mode write
    property p_oe_hold;
        $changed(gpio_oe_n) |-> $past(wr_mode) || $past(wr_mode, 2);
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("pin enable changed unasked");
    property p_level;
        $stable(gpio_in) [*5] |-> gpio_level_r == gpio_in;
    endproperty
    a_level: assert property (p_level) else $error("pin level not followed");
    // A long supply dip must show in the power flag
    property p_por;
        supply_low [*5] ##0 (rd_any && req.cmd.addr == ADDR_MODE) |=> rsp_r.rdata[MODE_POR_BIT];
    endproperty
    a_por: assert property (p_por) else $error("power flag not set");
    property p_brief_cause;
        brief_wake_r |-> $past(sleep_r) && $past(tick_fast);
    endproperty
    a_brief_cause: assert property (p_brief_cause) else $error("wake without tick in sleep");
    property p_brief_start;
        sleep_r && tick_fast && !brief_wake_r |=> brief_wake_r;
    endproperty
    a_brief_start: assert property (p_brief_start) else $error("tick in sleep gave no wake");

endmodule : cctr_asserts

bind cctr_top cctr_asserts chk_u (
    .mclk(mclk), .reset_n(reset_n), .req(req), .rsp_r(rsp_r), .tick_fast(tick_fast),
    .supply_low(supply_low), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .gpio_level_r(gpio_level_r), .sleep_r(sleep_r), .brief_wake_r(brief_wake_r));
`default_nettype wire

// ===== verification/tb.sv
`default_nettype none
module tb
    import cctr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LIMIT = 95000; // Cycle ceiling, run needs about 83000
    logic mclk = 1'b0; // System clock
    logic reset_n = 1'b0; // Power-on reset
    cctr_req_t req; // Host request
    cctr_rsp_t rsp_r; // Device answer
    cctr_sense_t sense = '0; // Integrator results
    logic tick_fast = 1'b0; // Timebase pulse
    logic [2:0] temp_band = 3'h7; // Hottest band
    logic [2:0] sense_mag = 3'h0; // Sense magnitude
    logic pd_cmd = 1'b0; // Power-down pulse
    logic link_wake = 1'b0; // Link transition
    logic supply_low = 1'b0; // Supply dip
    logic gpio_out; // Pin drive value
    logic gpio_oe_n; // Pin enable
    logic gpio_level_r; // Synced level
    logic sleep_r; // Asleep
    logic brief_wake_r; // Maintenance wake
    wire logic gpio_pin = gpio_oe_n ? 1'b1 : gpio_out; // Pull-up unless driven
    int err_total = 0; // Mismatches
    int samples_checked = 0; // Comparisons
    int cyc = 0; // Cycles run
    int wakes = 0; // Maintenance wakes seen
    logic [15:0] w [5] = '{16'h0001, 16'h0001, 16'h0101, 16'h0001, 16'h0001}; // Counts after burst
    logic [7:0] mt [4] = '{8'h00, 8'h81, 8'h40, 8'hFF}; // Mode values to try

    cctr_top dut_u (.mclk(mclk), .reset_n(reset_n), .req(req), .rsp_r(rsp_r), .sense(sense),
        .tick_fast(tick_fast), .temp_band(temp_band), .sense_mag(sense_mag), .pd_cmd(pd_cmd),
        .link_wake(link_wake), .supply_low(supply_low), .gpio_in(gpio_pin), .gpio_out(gpio_out),
        .gpio_oe_n(gpio_oe_n), .gpio_level_r(gpio_level_r), .sleep_r(sleep_r),
        .brief_wake_r(brief_wake_r));
    cctr_host_model host_u (.req(req), .mclk(mclk), .rsp(rsp_r));

    // 25 MHz clock
    always #20 mclk = ~mclk;

    // Verdict and end of run
    task automatic close_out();
        $display("Checked %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    // Watchdog, also counts wakes
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (brief_wake_r === 1'b1) begin
            wakes <= wakes + 1;
        end
        if (cyc == LIMIT) begin
            err_total++;
            close_out();
        end
    end

    // Byte compare
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    // Flag compare
    task automatic chk1(input string what, input logic exp, input logic got);
        chk8(what, {7'h00, exp}, {7'h00, got});
    endtask : chk1

    // Register read with expected byte
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic v;
        host_u.xfer(1'b0, a, 8'h00, q, v);
        chk1("answer valid", 1'b1, v);
        chk8($sformatf("reg %h", a), exp, q);
    endtask : rd

    // Register write
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic v;
        host_u.xfer(1'b1, a, d, q, v);
    endtask : wr

    // Counter word, low byte first
    task automatic cnt(input logic [6:0] lo, input logic [15:0] exp);
        rd(lo, exp[7:0]);
        rd(7'(lo + 1), exp[15:8]);
    endtask : cnt

    // Spaced one-cycle ticks
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk);
            tick_fast <= 1'b1;
            @(posedge mclk);
            tick_fast <= 1'b0;
        end
    endtask : tick

    // Power-down or wake pulse
    task automatic kick(input logic wake);
        @(posedge mclk);
        pd_cmd <= !wake;
        link_wake <= wake;
        @(posedge mclk);
        pd_cmd <= 1'b0;
        link_wake <= 1'b0;
    endtask : kick

    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        chk1("oe_n", 1'b1, gpio_oe_n);
        rd(ADDR_CLEAR, 8'h00);
        rd(ADDR_MODE, 8'h4F);
        for (int a = 8'h65; a <= 8'h6E; a++) begin
            rd(7'(a), 8'h00);
        end
        rd(7'h10, 8'h00);
        wr(ADDR_DC_LO, 8'hAA);
        rd(ADDR_DC_LO, 8'h00);
        // Burst: every counter but self-discharge wraps once, then slow rate takes over
        @(posedge mclk);
        sense <= 4'hF;
        tick_fast <= 1'b1;
        repeat (65537) @(posedge mclk);
        sense.chg_pulse <= 1'b0;
        sense.dchg_pulse <= 1'b0;
        repeat (255) @(posedge mclk);
        tick_fast <= 1'b0;
        sense <= '0;
        cnt(ADDR_DC_LO, w[0]);
        cnt(ADDR_CC_LO, w[1]);
        cnt(ADDR_SD_LO, w[2]);
        cnt(ADDR_DT_LO, w[3]);
        cnt(ADDR_CT_LO, w[4]);
        // One clear bit at a time, neighbours untouched
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_CLEAR, 8'(1 << i));
            rd(ADDR_CLEAR, 8'h00);
            cnt(7'(ADDR_DC_LO - 2 * i), 16'h0000);
            if (i < 4) begin
                cnt(7'(ADDR_DC_LO - 2 * i - 2), w[i + 1]);
            end
            rd(ADDR_MODE, 8'h4F | (i < 4 ? 8'h20 : 8'h00) | (i < 3 ? 8'h10 : 8'h00));
        end
        // Fast rate back after clearing
        sense.chg_active <= 1'b1;
        sense.dchg_active <= 1'b1;
        tick(1);
        sense <= '0;
        cnt(ADDR_CT_LO, 16'h0001);
        cnt(ADDR_DT_LO, 16'h0001);
        // Self-discharge rate per band, hottest first, 2048 ticks each
        for (int b = 7; b >= 0; b--) begin
            temp_band <= 3'(b);
            wr(ADDR_CLEAR, 8'h04);
            @(posedge mclk);
            tick_fast <= 1'b1;
            repeat (2048) @(posedge mclk);
            tick_fast <= 1'b0;
            cnt(ADDR_SD_LO, 16'(8 >> (7 - b)));
        end
        // Pin direction and level
        foreach (mt[k]) begin
            wr(ADDR_MODE, mt[k]);
            repeat (5) @(posedge mclk);
            chk1("oe_n", mt[k][7] | mt[k][6], gpio_oe_n);
            chk1("level", mt[k][7] | mt[k][6], gpio_level_r);
            rd(ADDR_MODE, mt[k] & 8'hCF);
        end
        // Supply dip sets the power flag
        wr(ADDR_MODE, 8'h4E);
        supply_low <= 1'b1;
        repeat (6) @(posedge mclk);
        rd(ADDR_MODE, 8'h4F);
        supply_low <= 1'b0;
        // Sleep only once the sense magnitude drops under the threshold
        wr(ADDR_MODE, 8'h46);
        sense_mag <= 3'h5;
        kick(1'b0);
        repeat (4) @(posedge mclk);
        chk1("sleep", 1'b0, sleep_r);
        sense_mag <= 3'h2;
        repeat (4) @(posedge mclk);
        chk1("sleep", 1'b1, sleep_r);
        sense.chg_active <= 1'b1;
        temp_band <= 3'h7;
        tick(4);
        repeat (2) @(posedge mclk);
        chk8("wakes", 8'h04, 8'(wakes));
        tick(252);
        kick(1'b1);
        repeat (2) @(posedge mclk);
        sense <= '0;
        chk1("sleep", 1'b0, sleep_r);
        cnt(ADDR_SD_LO, 16'h0001);
        cnt(ADDR_CT_LO, 16'h0001);
        // Zero threshold sleeps at once
        wr(ADDR_MODE, 8'h40);
        sense_mag <= 3'h7;
        kick(1'b0);
        repeat (4) @(posedge mclk);
        chk1("sleep", 1'b1, sleep_r);
        close_out();
    end

endmodule : tb
`default_nettype wire
